// *** include/pabm_pkg.sv ***
// package for the port a/b pin function mux
package pabm_pkg;
   // pin indices inside the seven-pin group
   localparam int unsigned PIN_COUNT  = 7;
   localparam int unsigned PIN_B2     = 0; // port_b_pin_2: miso / timer ch2
   localparam int unsigned PIN_B3     = 1; // port_b_pin_3: mosi / timer ch3
   localparam int unsigned PIN_A0     = 2; // port_a_pin_0: pulse_out_0
   localparam int unsigned PIN_A1     = 3; // port_a_pin_1: pulse_out_1
   localparam int unsigned PIN_A2     = 4; // port_a_pin_2: pulse_out_2
   localparam int unsigned PIN_A4     = 5; // pulse_out_4/fault_1/timer ch2
   localparam int unsigned PIN_A5     = 6; // pulse_out_5/fault_2/timer ch3
   localparam int unsigned PULSE_COUNT = 6;
   localparam int unsigned FAULT_COUNT = 2;
   // per-pin function select codes
   localparam int unsigned SEL_W      = 2;
   typedef logic [SEL_W-1:0] pabm_sel_t;
   localparam pabm_sel_t SEL_GPIO     = 2'h0;
   localparam pabm_sel_t SEL_ALT_A    = 2'h1; // spi on b, pulse on a
   localparam pabm_sel_t SEL_ALT_B    = 2'h2; // timer on b, fault on a4/a5
   localparam pabm_sel_t SEL_ALT_C    = 2'h3; // timer on a4/a5
   localparam pabm_sel_t SEL_RESET    = SEL_GPIO;
   localparam logic      PULLUP_RESET = 1'b1;
   localparam logic      DIR_RESET    = 1'b0; // input
   typedef logic [PIN_COUNT-1:0]   pabm_pins_t;
   typedef logic [PULSE_COUNT-1:0] pabm_pulse_t;
   typedef logic [FAULT_COUNT-1:0] pabm_fault_t;
   // fault pin location of each fault input
   localparam int unsigned FAULT_INPUT_1_PIN = PIN_A4;
   localparam int unsigned FAULT_INPUT_2_PIN = PIN_A5;
   // pulse output carried on each port a pin
   localparam int unsigned PULSE_ON_A0 = 0;
   localparam int unsigned PULSE_ON_A1 = 1;
   localparam int unsigned PULSE_ON_A2 = 2;
   localparam int unsigned PULSE_ON_A4 = 4;
   localparam int unsigned PULSE_ON_A5 = 5;
endpackage : pabm_pkg

// *** design/pabm_pin_mux.sv ***
// port a/b pin function multiplexer
`timescale 1ns/1ps
module pabm_pin_mux
(
   input  wire logic                  CORE_CLK_I,
   input  wire logic                  RESETN_I,
   // configuration from the system integration module
   input  wire pabm_pkg::pabm_pins_t  CFG_WE_I,
   input  wire pabm_pkg::pabm_sel_t   CFG_SEL_I,
   input  wire pabm_pkg::pabm_pins_t  CFG_DIR_I,
   input  wire pabm_pkg::pabm_pins_t  CFG_PULLUP_I,
   input  wire pabm_pkg::pabm_fault_t CFG_FAULT_EN_I,
   input  wire pabm_pkg::pabm_pulse_t CFG_FAULT_INPUT_1_MASK_I,
   input  wire pabm_pkg::pabm_pulse_t CFG_FAULT_INPUT_2_MASK_I,
   // general-purpose port data
   input  wire pabm_pkg::pabm_pins_t  GPIO_OUT_I,
   output      pabm_pkg::pabm_pins_t  GPIO_IN_O,
   output logic [13:0]                SEL_STATE_O,
   // spi core
   input  wire logic                  SPI_MASTER_I,
   input  wire logic                  SPI_SLAVE_SEL_I,
   input  wire logic                  SPI_MOSI_I,
   input  wire logic                  SPI_MISO_I,
   output logic                       SPI_MOSI_O,
   output logic                       SPI_MISO_O,
   // pulse unit and timer
   input  wire pabm_pkg::pabm_pulse_t PULSE_I,
   output      pabm_pkg::pabm_fault_t FAULT_O,
   input  wire logic                  TMR2_OUT_I,
   input  wire logic                  TMR2_OE_I,
   input  wire logic                  TMR3_OUT_I,
   input  wire logic                  TMR3_OE_I,
   output logic                       TMR2_IN_O,
   output logic                       TMR3_IN_O,
   // pads
   input  wire pabm_pkg::pabm_pins_t  PAD_I,
   output      pabm_pkg::pabm_pins_t  PAD_O,
   output      pabm_pkg::pabm_pins_t  PAD_OE_O,
   output      pabm_pkg::pabm_pins_t  PAD_PULLUP_O
);
   import pabm_pkg::*;

   //------------------------------------------------------------
   // configuration state
   //------------------------------------------------------------
   pabm_sel_t  sel_r [PIN_COUNT];
   pabm_pins_t dir_r;
   pabm_pins_t pullup_r;
   pabm_fault_t fault_en_r;
   pabm_pulse_t fmask_r [FAULT_COUNT];
   logic        in_reset_r;

   always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         for (int i = 0; i < PIN_COUNT; i++)
            sel_r[i] <= SEL_RESET;
      end
      else
      begin
         for (int i = 0; i < PIN_COUNT; i++)
            if (CFG_WE_I[i])
               sel_r[i] <= CFG_SEL_I;
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         dir_r    <= {PIN_COUNT{DIR_RESET}};
         pullup_r <= {PIN_COUNT{PULLUP_RESET}};
      end
      else
      begin
         for (int i = 0; i < PIN_COUNT; i++)
            if (CFG_WE_I[i])
            begin
               dir_r[i]    <= CFG_DIR_I[i];
               pullup_r[i] <= CFG_PULLUP_I[i];
            end
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         fault_en_r <= '0;
         fmask_r[0] <= '0;
         fmask_r[1] <= '0;
      end
      else
      begin
         fault_en_r <= CFG_FAULT_EN_I;
         fmask_r[0] <= CFG_FAULT_INPUT_1_MASK_I;
         fmask_r[1] <= CFG_FAULT_INPUT_2_MASK_I;
      end
   end

   // held high until the first edge after release
   always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
         in_reset_r <= 1'b1;
      else
         in_reset_r <= 1'b0;
   end

   //------------------------------------------------------------
   // fault gating of pulse outputs
   //------------------------------------------------------------
   pabm_fault_t fault_act;
   pabm_pulse_t pulse_kill;
   pabm_pulse_t pulse_g;

   always_comb
   begin
      // fault pins are active low with pull-up idle
      fault_act[0] = fault_en_r[0] && sel_r[FAULT_INPUT_1_PIN] == SEL_ALT_B
                     && !PAD_I[FAULT_INPUT_1_PIN];
      fault_act[1] = fault_en_r[1] && sel_r[FAULT_INPUT_2_PIN] == SEL_ALT_B
                     && !PAD_I[FAULT_INPUT_2_PIN];
      pulse_kill = ({PULSE_COUNT{fault_act[0]}} & fmask_r[0])
                 | ({PULSE_COUNT{fault_act[1]}} & fmask_r[1]);
      pulse_g    = PULSE_I & ~pulse_kill;
   end

   //------------------------------------------------------------
   // pad drive
   //------------------------------------------------------------
   pabm_pins_t alt_oe;
   pabm_pins_t alt_val;
   pabm_pins_t is_alt;

   always_comb
   begin
      alt_oe  = '0;
      alt_val = '0;
      for (int i = 0; i < PIN_COUNT; i++)
         is_alt[i] = (sel_r[i] != SEL_GPIO);
      // miso half-clock lead is the spi core's timing, passed through
      unique case (sel_r[PIN_B2])
         SEL_ALT_A:
         begin
            alt_oe[PIN_B2]  = !SPI_MASTER_I
                              && SPI_SLAVE_SEL_I;
            alt_val[PIN_B2] = SPI_MISO_I;
         end
         SEL_ALT_B, SEL_ALT_C:
         begin
            alt_oe[PIN_B2]  = TMR2_OE_I;
            alt_val[PIN_B2] = TMR2_OUT_I;
         end
         SEL_GPIO: ;
      endcase
      unique case (sel_r[PIN_B3])
         SEL_ALT_A:
         begin
            alt_oe[PIN_B3]  = SPI_MASTER_I;
            alt_val[PIN_B3] = SPI_MOSI_I;
         end
         SEL_ALT_B, SEL_ALT_C:
         begin
            alt_oe[PIN_B3]  = TMR3_OE_I;
            alt_val[PIN_B3] = TMR3_OUT_I;
         end
         SEL_GPIO: ;
      endcase
      alt_oe[PIN_A0]  = 1'b1;
      alt_val[PIN_A0] = pulse_g[PULSE_ON_A0];
      alt_oe[PIN_A1]  = 1'b1;
      alt_val[PIN_A1] = pulse_g[PULSE_ON_A1];
      alt_oe[PIN_A2]  = 1'b1;
      alt_val[PIN_A2] = pulse_g[PULSE_ON_A2];
      unique case (sel_r[PIN_A4])
         SEL_ALT_A:
         begin
            alt_oe[PIN_A4]  = 1'b1;
            alt_val[PIN_A4] = pulse_g[PULSE_ON_A4];
         end
         SEL_ALT_C:
         begin
            alt_oe[PIN_A4]  = TMR2_OE_I;
            alt_val[PIN_A4] = TMR2_OUT_I;
         end
         SEL_ALT_B, SEL_GPIO: ;
      endcase
      unique case (sel_r[PIN_A5])
         SEL_ALT_A:
         begin
            alt_oe[PIN_A5]  = 1'b1;
            alt_val[PIN_A5] = pulse_g[PULSE_ON_A5];
         end
         SEL_ALT_C:
         begin
            alt_oe[PIN_A5]  = TMR3_OE_I;
            alt_val[PIN_A5] = TMR3_OUT_I;
         end
         SEL_ALT_B, SEL_GPIO: ;
      endcase
   end

   always_comb
   begin
      for (int i = 0; i < PIN_COUNT; i++)
      begin
         if (in_reset_r)
         begin
            PAD_OE_O[i]     = 1'b0;
            PAD_O[i]        = 1'b0;
            PAD_PULLUP_O[i] = 1'b1;
         end
         else if (is_alt[i])
         begin
            PAD_OE_O[i]     = alt_oe[i];
            PAD_O[i]        = alt_val[i];
            PAD_PULLUP_O[i] = pullup_r[i] & ~alt_oe[i];
         end
         else
         begin
            PAD_OE_O[i]     = dir_r[i];
            PAD_O[i]        = GPIO_OUT_I[i];
            PAD_PULLUP_O[i] = pullup_r[i] & ~dir_r[i];
         end
      end
   end

   //------------------------------------------------------------
   // inputs back to the cores
   //------------------------------------------------------------
   always_comb
   begin
      GPIO_IN_O  = PAD_I;
      SPI_MOSI_O = (sel_r[PIN_B3] == SEL_ALT_A) ? PAD_I[PIN_B3] : 1'b0;
      SPI_MISO_O = (sel_r[PIN_B2] == SEL_ALT_A) ? PAD_I[PIN_B2] : 1'b0;
      FAULT_O    = fault_act;
      TMR2_IN_O  = (sel_r[PIN_A4] == SEL_ALT_C) ? PAD_I[PIN_A4]
                 : (sel_r[PIN_B2] inside {SEL_ALT_B, SEL_ALT_C})
                   ? PAD_I[PIN_B2] : 1'b0;
      TMR3_IN_O  = (sel_r[PIN_A5] == SEL_ALT_C) ? PAD_I[PIN_A5]
                 : (sel_r[PIN_B3] inside {SEL_ALT_B, SEL_ALT_C})
                   ? PAD_I[PIN_B3] : 1'b0;
      for (int i = 0; i < PIN_COUNT; i++)
         SEL_STATE_O[2*i +: 2] = sel_r[i];
   end

   //------------------------------------------------------------
   // checks
   //------------------------------------------------------------
   property p_reset_pads;
      @(posedge CORE_CLK_I) in_reset_r |-> (PAD_OE_O == '0)
         && (PAD_PULLUP_O == '1);
   endproperty
   a_reset_pads: assert property (p_reset_pads)
      else $error("pad driven during reset");

   property p_release_gpio;
      @(posedge CORE_CLK_I) $rose(RESETN_I) |-> sel_r[PIN_A0] == SEL_GPIO
         && sel_r[PIN_B2] == SEL_GPIO && sel_r[PIN_A5] == SEL_GPIO;
   endproperty
   a_release_gpio: assert property (p_release_gpio)
      else $error("pin not gpio after reset");

   property p_gpio_dir;
      @(posedge CORE_CLK_I) disable iff (!RESETN_I)
      CFG_WE_I[PIN_A1] && CFG_SEL_I == SEL_GPIO ##1 !CFG_WE_I[PIN_A1]
      |-> PAD_OE_O[PIN_A1] == $past(CFG_DIR_I[PIN_A1]);
   endproperty
   a_gpio_dir: assert property (p_gpio_dir)
      else $error("gpio direction not applied");

   property p_miso_dir;
      @(posedge CORE_CLK_I) disable iff (!RESETN_I)
      !in_reset_r && sel_r[PIN_B2] == SEL_ALT_A
      |-> PAD_OE_O[PIN_B2] == (!SPI_MASTER_I && SPI_SLAVE_SEL_I);
   endproperty
   a_miso_dir: assert property (p_miso_dir)
      else $error("miso direction wrong");

   property p_miso_hiz;
      @(posedge CORE_CLK_I) disable iff (!RESETN_I)
      sel_r[PIN_B2] == SEL_ALT_A && !SPI_SLAVE_SEL_I |-> !PAD_OE_O[PIN_B2];
   endproperty
   a_miso_hiz: assert property (p_miso_hiz)
      else $error("unselected slave drives miso");

   property p_mosi_dir;
      @(posedge CORE_CLK_I) disable iff (!RESETN_I)
      !in_reset_r && sel_r[PIN_B3] == SEL_ALT_A
      |-> PAD_OE_O[PIN_B3] == SPI_MASTER_I && PAD_O[PIN_B3] == SPI_MOSI_I;
   endproperty
   a_mosi_dir: assert property (p_mosi_dir)
      else $error("mosi direction wrong");

   property p_fault_kill;
      @(posedge CORE_CLK_I) disable iff (!RESETN_I)
      !in_reset_r && sel_r[PIN_A0] == SEL_ALT_A && fault_act[0]
      && fmask_r[0][PULSE_ON_A0] |-> !PAD_O[PIN_A0];
   endproperty
   a_fault_kill: assert property (p_fault_kill)
      else $error("faulted pulse output still active");

   property p_timer_a4;
      @(posedge CORE_CLK_I) disable iff (!RESETN_I)
      !in_reset_r && sel_r[PIN_A4] == SEL_ALT_C
      |-> PAD_O[PIN_A4] == TMR2_OUT_I && PAD_OE_O[PIN_A4] == TMR2_OE_I;
   endproperty
   a_timer_a4: assert property (p_timer_a4)
      else $error("timer 2 not routed to port a pin 4");

   property p_alt_owns;
      @(posedge CORE_CLK_I) disable iff (!RESETN_I)
      !in_reset_r && sel_r[PIN_A2] == SEL_ALT_A
      |-> PAD_OE_O[PIN_A2] && PAD_O[PIN_A2] == pulse_g[PULSE_ON_A2];
   endproperty
   a_alt_owns: assert property (p_alt_owns)
      else $error("gpio still owns alternate pin");

   c_slave_miso: cover property (@(posedge CORE_CLK_I)
      PAD_OE_O[PIN_B2] && sel_r[PIN_B2] == SEL_ALT_A);
   c_fault: cover property (@(posedge CORE_CLK_I) |fault_act);
   c_timer3_a5: cover property (@(posedge CORE_CLK_I)
      sel_r[PIN_A5] == SEL_ALT_C && PAD_OE_O[PIN_A5]);
endmodule : pabm_pin_mux

// *** verif/pabm_pad_partner.sv ***
// pad partner: off-chip spi devices and fault sources on the pins
`timescale 1ns/1ps
module pabm_pad_partner
(
   input  wire logic                  clk_i,
   input  wire pabm_pkg::pabm_pins_t  pad_o_i,
   input  wire pabm_pkg::pabm_pins_t  pad_oe_i,
   input  wire pabm_pkg::pabm_pins_t  pad_pu_i,
   input  wire pabm_pkg::pabm_pins_t  drv_i,
   input  wire pabm_pkg::pabm_pins_t  val_i,
   output      pabm_pkg::pabm_pins_t  pad_i_o
);
   import pabm_pkg::*;
   // --------------------------------------------------
   // wire level seen by the device
   // --------------------------------------------------
   pabm_pins_t float_r = 7'h55;
   // an undriven pin without pull-up must not look stable
   always @(posedge clk_i)
      float_r <= ~float_r;
   always_comb
   begin
      for (int i = 0; i < PIN_COUNT; i++)
      begin
         if (pad_oe_i[i])
            pad_i_o[i] = pad_o_i[i];
         else if (drv_i[i])
            pad_i_o[i] = val_i[i];
         else if (pad_pu_i[i])
            pad_i_o[i] = 1'b1;
         else
            pad_i_o[i] = float_r[i];
      end
   end
endmodule : pabm_pad_partner

// *** verif/test_port_ab_pin_function_mux.sv ***
// self-checking bench for the port a/b pin function mux
`timescale 1ns/1ps
module test_port_ab_pin_function_mux;
   import pabm_pkg::*;
   logic        CORE_CLK_I = 1'b0;
   logic        RESETN_I   = 1'b0;
   pabm_pins_t  CFG_WE_I, CFG_DIR_I, CFG_PULLUP_I, GPIO_OUT_I, PAD_I;
   pabm_pins_t  GPIO_IN_O, PAD_O, PAD_OE_O, PAD_PULLUP_O, ext_drv, ext_val;
   pabm_sel_t   CFG_SEL_I;
   pabm_fault_t CFG_FAULT_EN_I, FAULT_O;
   pabm_pulse_t CFG_FAULT_INPUT_1_MASK_I, CFG_FAULT_INPUT_2_MASK_I, PULSE_I, m1_m, m2_m;
   logic [13:0] SEL_STATE_O;
   logic        SPI_MASTER_I, SPI_SLAVE_SEL_I, SPI_MOSI_I, SPI_MISO_I;
   logic        SPI_MOSI_O, SPI_MISO_O, TMR2_IN_O, TMR3_IN_O;
   logic        TMR2_OUT_I, TMR2_OE_I, TMR3_OUT_I, TMR3_OE_I;
   pabm_fault_t en_m        = '0;
   pabm_pins_t  dir_m       = '0;
   pabm_pins_t  pu_m        = '1;
   int          sel [PIN_COUNT] = '{default: 0};
   int          fails       = 0;
   int          comparisons = 0;
   logic [31:0] seed        = 32'h0000e24d;

   always #5 CORE_CLK_I = ~CORE_CLK_I;

   pabm_pin_mux u_pabm_pin_mux (.CORE_CLK_I, .RESETN_I, .CFG_WE_I, .CFG_SEL_I,
      .CFG_DIR_I, .CFG_PULLUP_I, .CFG_FAULT_EN_I, .CFG_FAULT_INPUT_1_MASK_I,
      .CFG_FAULT_INPUT_2_MASK_I, .GPIO_OUT_I, .GPIO_IN_O, .SEL_STATE_O,
      .SPI_MASTER_I, .SPI_SLAVE_SEL_I, .SPI_MOSI_I, .SPI_MISO_I, .SPI_MOSI_O,
      .SPI_MISO_O, .PULSE_I, .FAULT_O, .TMR2_OUT_I, .TMR2_OE_I, .TMR3_OUT_I,
      .TMR3_OE_I, .TMR2_IN_O, .TMR3_IN_O, .PAD_I, .PAD_O, .PAD_OE_O,
      .PAD_PULLUP_O);
   pabm_pad_partner u_pabm_pad_partner (.clk_i(CORE_CLK_I), .pad_o_i(PAD_O),
      .pad_oe_i(PAD_OE_O), .pad_pu_i(PAD_PULLUP_O), .drv_i(ext_drv),
      .val_i(ext_val), .pad_i_o(PAD_I));

   // --------------------------------------------------
   // reference model of the configuration state
   // --------------------------------------------------
   always @(posedge CORE_CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         sel = '{default: 0};
         dir_m = '0;
         pu_m = '1;
         en_m = '0;
         m1_m = '0;
         m2_m = '0;
      end
      else
      begin
         for (int i = 0; i < PIN_COUNT; i++)
            if (CFG_WE_I[i])
            begin
               sel[i] = CFG_SEL_I;
               dir_m[i] = CFG_DIR_I[i];
               pu_m[i] = CFG_PULLUP_I[i];
            end
         en_m = CFG_FAULT_EN_I;
         m1_m = CFG_FAULT_INPUT_1_MASK_I;
         m2_m = CFG_FAULT_INPUT_2_MASK_I;
      end
   end

   // expected {killed pulse, drive enable, value} of one pin
   function automatic logic [2:0] pexp(input int i, input pabm_pulse_t kl);
      int s;
      int k;
      s = sel[i];
      if (s == 0)
         return {1'b0, dir_m[i], GPIO_OUT_I[i]};
      if (i == PIN_B2 && s == 1)
         return {1'b0, !SPI_MASTER_I && SPI_SLAVE_SEL_I, SPI_MISO_I};
      if (i == PIN_B3 && s == 1)
         return {1'b0, SPI_MASTER_I, SPI_MOSI_I};
      if (i == PIN_B2 || (i == PIN_A4 && s == 3))
         return {1'b0, TMR2_OE_I, TMR2_OUT_I};
      if (i == PIN_B3 || (i == PIN_A5 && s == 3))
         return {1'b0, TMR3_OE_I, TMR3_OUT_I};
      if (i >= PIN_A4 && s == 2)
         return 3'h0;
      k = (i >= PIN_A4) ? i - 1 : i - PIN_A0;
      return {kl[k], 1'b1, PULSE_I[k] & !kl[k]};
   endfunction : pexp

   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   task automatic cmp(input string n, input logic [13:0] g,
                      input logic [13:0] e);
      comparisons++;
      if (g !== e)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : cmp

   task automatic check();
      pabm_pins_t  eo, eh, pm;
      logic [2:0]  p;
      logic [13:0] ss;
      logic [1:0]  sp;
      pabm_fault_t fa;
      pabm_pulse_t kl;
      fa[0] = en_m[0] && sel[PIN_A4] == 2 && PAD_I[PIN_A4] == 1'b0;
      fa[1] = en_m[1] && sel[PIN_A5] == 2 && PAD_I[PIN_A5] == 1'b0;
      kl = ({6{fa[0]}} & m1_m) | ({6{fa[1]}} & m2_m);
      for (int i = 0; i < PIN_COUNT; i++)
      begin
         p = pexp(i, kl);
         {pm[i], eo[i], eh[i]} = {p[2], p[1], p[1] & p[0]};
         ss[2*i +: 2] = sel[i][1:0];
      end
      sp[1] = sel[PIN_B3] == 1 && PAD_I[PIN_B3];
      sp[0] = sel[PIN_B2] == 1 && PAD_I[PIN_B2];
      cmp("pad_oe", 14'(PAD_OE_O | pm), 14'(eo | pm));
      cmp("drive", 14'(PAD_OE_O & PAD_O), 14'(eh));
      cmp("pullup", 14'(PAD_PULLUP_O), 14'(pu_m & ~eo));
      cmp("sel_state", SEL_STATE_O, ss);
      cmp("fault", 14'(FAULT_O), 14'(fa));
      cmp("gpio_in", 14'(GPIO_IN_O), 14'(PAD_I));
      cmp("spi_in", 14'({SPI_MOSI_O, SPI_MISO_O}), 14'(sp));
      sp[0] = sel[PIN_A4] == 3 ? PAD_I[PIN_A4]
            : (sel[PIN_B2] > 1 && PAD_I[PIN_B2]);
      sp[1] = sel[PIN_A5] == 3 ? PAD_I[PIN_A5]
            : (sel[PIN_B3] > 1 && PAD_I[PIN_B3]);
      cmp("tmr2_in", 14'(TMR2_IN_O), 14'(sp[0]));
      cmp("tmr3_in", 14'(TMR3_IN_O), 14'(sp[1]));
      if (!RESETN_I)
         cmp("pad_rst", 14'(PAD_O), 14'h0000);
   endtask : check

   always @(negedge CORE_CLK_I)
      check();

   // --------------------------------------------------
   // stimulus
   // --------------------------------------------------
   task automatic drive(input logic we);
      logic [31:0] a;
      logic [31:0] b;
      logic [31:0] c;
      a = rnd();
      b = rnd();
      c = rnd();
      {CFG_SEL_I, CFG_DIR_I, CFG_PULLUP_I, CFG_FAULT_EN_I, SPI_MASTER_I,
       SPI_SLAVE_SEL_I, SPI_MOSI_I, SPI_MISO_I, TMR2_OUT_I} = a[22:0];
      {GPIO_OUT_I, PULSE_I, CFG_FAULT_INPUT_1_MASK_I, CFG_FAULT_INPUT_2_MASK_I, TMR2_OE_I,
       TMR3_OUT_I, TMR3_OE_I} = b[27:0];
      {ext_drv, ext_val} = c[13:0];
      CFG_WE_I = we ? c[20:14] : 7'h00;
   endtask : drive

   task automatic run(input int n, input logic we);
      repeat (n)
      begin
         @(posedge CORE_CLK_I);
         #1;
         drive(we);
      end
   endtask : run

   task automatic results();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : results

   initial
   begin
      drive(1'b0);
      run(3, 1'b0);
      RESETN_I = 1'b1;
      run(1, 1'b0);
      run(3000, 1'b1);
      RESETN_I = 1'b0;
      run(3, 1'b0);
      RESETN_I = 1'b1;
      run(1, 1'b0);
      run(1000, 1'b1);
      results();
   end
endmodule : test_port_ab_pin_function_mux
